// >>> rtl/mcf_consts.svh
// Constants for the motion command frame interpreter.
// Assumes inclusion by the interpreter module only.
`ifndef MCF_CONSTS_SVH
`define MCF_CONSTS_SVH
`define MCF_BODY_BYTES 4'h7
`define MCF_FRAME_BYTES 4'h9
`define MCF_BYTE_CMD 4'h1
`define MCF_BYTE_TYPE 4'h2
`define MCF_BYTE_BANK 4'h3
`define MCF_BYTE_VAL0 4'h4
`define MCF_BYTE_VAL3 4'h7
`define MCF_BYTE_CSUM 4'h8
`define MCF_ST_OK 8'h64
`define MCF_ST_STORED 8'h65
`define MCF_ST_CSUM 8'h01
`define MCF_ST_BADCMD 8'h02
`define MCF_ST_BADTYPE 8'h03
`define MCF_ST_BADVAL 8'h04
`define MCF_ST_LOCKED 8'h05
`define MCF_ST_NA 8'h06
`endif

// >>> rtl/mcf_pkg.sv
// Types for the motion command frame interpreter.
// Assumes mcf_consts.svh sits in the include path.
package mcf_pkg;
	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] typ;
		logic [7:0] bank;
		logic [31:0] value;
	} mcf_cmd_s;
	typedef struct packed {
		logic [7:0] status;
		logic [31:0] value;
	} mcf_res_s;
	typedef enum logic [5:0] {
		MCF_RX = 6'h01,
		MCF_SRC = 6'h02,
		MCF_EXEC = 6'h04,
		MCF_WAIT = 6'h08,
		MCF_TX = 6'h10,
		MCF_DONE = 6'h20
	} mcf_state_e;
endpackage

// >>> rtl/mcf_interp.sv
// Command frame interpreter: receives frames byte by byte, runs each command
// through an executor port unless its serial checksum fails, replies to host commands with one status frame.
// Assumes byte strobes synchronous to clk_sys; executor answers with a pulse.
`timescale 1ns/100ps
`include "mcf_consts.svh"
// Operation
// - Transmit only as reply to a command
// - Receive by default, drive bus only replying
// - Body: command, type, bank, four-byte value
// - Serial frame adds address and checksum bytes
// - Command checksum sums all preceding bytes
// - Exactly one reply per host command
// - Reply: addresses, status, command, value, checksum
// - Reply checksum sums all other bytes
// - CAN command omits address and checksum
// - CAN reply omits address and checksum
// - Status 100 executed, 101 stored
// - Error statuses one through six
// - Finish action before starting reply
// - Program memory may issue same commands
module mcf_interp
	import mcf_pkg::*;
#(
	parameter logic [7:0] MODULE_ADDR = 8'h01,
	parameter logic [7:0] REPLY_ADDR = 8'h02
)
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic can_mode,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic tx_drive,
	input wire logic prog_valid,
	input wire mcf_pkg::mcf_cmd_s prog_cmd,
	output logic prog_ack,
	output mcf_pkg::mcf_cmd_s exec_cmd,
	output logic exec_start,
	input wire logic exec_done,
	input wire mcf_pkg::mcf_res_s exec_res,
	output logic cmd_error
);
	import mcf_pkg::*;

	mcf_state_e state, next_state;
	logic [3:0] idx, next_idx;
	logic [7:0] sum, next_sum;
	logic csum_bad, next_csum_bad;
	logic skip, next_skip;
	logic from_prog, next_from_prog;
	mcf_cmd_s cmd, next_cmd;
	mcf_res_s res, next_res;
	logic [7:0] next_tx_data;
	logic next_tx_valid, next_tx_drive, next_prog_ack, next_exec_start, next_cmd_error;
	logic [3:0] pos;

	function automatic logic [3:0] last_idx(input logic can);
		last_idx = can ? (`MCF_BODY_BYTES - 4'h1) : (`MCF_FRAME_BYTES - 4'h1);
	endfunction

	// Reply byte at position i, serial numbering; CAN uses bytes 2..7
	function automatic logic [7:0] reply_byte(input logic [3:0] i, input mcf_res_s r,
			input logic [7:0] c, input logic [7:0] s);
		case (i)
			4'h0: reply_byte = REPLY_ADDR;
			4'h1: reply_byte = MODULE_ADDR;
			4'h2: reply_byte = r.status;
			4'h3: reply_byte = c;
			4'h4: reply_byte = r.value[31:24];
			4'h5: reply_byte = r.value[23:16];
			4'h6: reply_byte = r.value[15:8];
			4'h7: reply_byte = r.value[7:0];
			default: reply_byte = s;
		endcase
	endfunction

	always_comb
	begin
		next_state = state;
		next_idx = idx;
		next_sum = sum;
		next_csum_bad = csum_bad;
		next_skip = skip;
		next_from_prog = from_prog;
		next_cmd = cmd;
		next_res = res;
		next_tx_data = tx_data;
		next_tx_valid = tx_valid;
		next_tx_drive = tx_drive;
		next_prog_ack = 1'b0;
		next_exec_start = 1'b0;
		next_cmd_error = 1'b0;
		// CAN position offset by one so field indices match serial layout
		pos = can_mode ? idx + 4'h1 : idx;
		case (state)
			MCF_RX:
			begin
				if (rx_valid)
				begin
					next_sum = sum + rx_data;
					if (!can_mode && idx == 4'h0 && rx_data != MODULE_ADDR)
						next_skip = 1'b1;
					case (pos)
						`MCF_BYTE_CMD: next_cmd.cmd = rx_data;
						`MCF_BYTE_TYPE: next_cmd.typ = rx_data;
						`MCF_BYTE_BANK: next_cmd.bank = rx_data;
						`MCF_BYTE_CSUM: next_csum_bad = (rx_data != sum);
						default:
							if (pos >= `MCF_BYTE_VAL0 && pos <= `MCF_BYTE_VAL3)
								next_cmd.value = {cmd.value[23:0], rx_data};
					endcase
					if (idx == last_idx(can_mode))
					begin
						next_idx = 4'h0;
						next_sum = 8'h00;
						next_skip = 1'b0;
						next_from_prog = 1'b0;
						// Skipped frames end silently; no reply without own command
						if (!(skip || (!can_mode && idx == 4'h0 && rx_data != MODULE_ADDR)))
							next_state = MCF_EXEC;
					end
					else
						next_idx = idx + 4'h1;
				end
				else if (prog_valid && idx == 4'h0)
				begin
					// Program engine only between host frames, so frames never mix
					next_cmd = prog_cmd;
					next_from_prog = 1'b1;
					next_csum_bad = 1'b0;
					next_prog_ack = 1'b1;
					next_state = MCF_EXEC;
				end
			end
			MCF_EXEC:
			begin
				next_state = MCF_SRC;
				if (csum_bad && !can_mode && !from_prog)
				begin
					next_res.status = `MCF_ST_CSUM;
					next_res.value = 32'h0000_0000;
					next_cmd_error = 1'b1;
				end
				else
				begin
					next_exec_start = 1'b1;
					next_state = MCF_WAIT;
				end
			end
			MCF_WAIT:
				if (exec_done)
				begin
					next_res = exec_res;
					next_cmd_error = exec_res.status < `MCF_ST_OK;
					next_state = MCF_SRC;
				end
			MCF_SRC:
			begin
				// Program commands get no host reply
				if (from_prog)
					next_state = MCF_RX;
				else
				begin
					next_idx = can_mode ? 4'h2 : 4'h0;
					next_sum = 8'h00;
					next_state = MCF_TX;
				end
			end
			MCF_TX:
			begin
				next_tx_drive = 1'b1;
				if (!tx_valid || tx_ready)
				begin
					next_tx_data = reply_byte(idx, res, cmd.cmd, sum);
					next_sum = sum + reply_byte(idx, res, cmd.cmd, sum);
					next_tx_valid = 1'b1;
					if (idx == (can_mode ? `MCF_BYTE_VAL3 : `MCF_BYTE_CSUM))
						next_state = MCF_DONE;
					else
						next_idx = idx + 4'h1;
				end
			end
			MCF_DONE:
				if (tx_ready)
				begin
					next_tx_valid = 1'b0;
					next_tx_drive = 1'b0;
					next_idx = 4'h0;
					next_sum = 8'h00;
					next_state = MCF_RX;
				end
			default: next_state = MCF_RX;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			state <= MCF_RX;
			idx <= 4'h0;
			sum <= 8'h00;
			csum_bad <= 1'b0;
			skip <= 1'b0;
			from_prog <= 1'b0;
			cmd <= '0;
			res <= '0;
			tx_data <= 8'h00;
			tx_valid <= 1'b0;
			tx_drive <= 1'b0;
			prog_ack <= 1'b0;
			exec_start <= 1'b0;
			cmd_error <= 1'b0;
		end
		else
		begin
			state <= next_state;
			idx <= next_idx;
			sum <= next_sum;
			csum_bad <= next_csum_bad;
			skip <= next_skip;
			from_prog <= next_from_prog;
			cmd <= next_cmd;
			res <= next_res;
			tx_data <= next_tx_data;
			tx_valid <= next_tx_valid;
			tx_drive <= next_tx_drive;
			prog_ack <= next_prog_ack;
			exec_start <= next_exec_start;
			cmd_error <= next_cmd_error;
		end
	end

	assign exec_cmd = cmd;
endmodule // mcf_interp

// >>> dv/mcf_interp_sva.sv
// Checker for the reply side of the frame interpreter.
// Assumes bind into mcf_interp, one clock domain.
`timescale 1ns/100ps
module mcf_interp_sva
	import mcf_pkg::*;
#(
	parameter logic [7:0] REPLY_ADDR = 8'h02
)
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic can_mode,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic tx_drive,
	input wire logic exec_start,
	input wire logic prog_ack
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence s_stall;
		tx_valid && !tx_ready;
	endsequence
	sequence s_held;
		tx_valid && $stable(tx_data);
	endsequence
	chk_tx_hold: assert property (s_stall |=> s_held)
		else $error("reply byte changed before acceptance");
	chk_drive_cover: assert property (tx_valid |-> tx_drive)
		else $error("reply byte without bus drive");
	chk_drive_release: assert property ($fell(tx_valid) |-> !tx_drive)
		else $error("bus held after reply");
	chk_first_addr: assert property ($rose(tx_valid) && !can_mode |-> tx_data == REPLY_ADDR)
		else $error("reply does not open with reply address");
	chk_start_pulse: assert property (exec_start |=> !exec_start)
		else $error("execute strobe longer than one cycle");
	chk_exec_quiet: assert property (exec_start |-> !tx_drive)
		else $error("reply under way while executing");
	chk_ack_pulse: assert property (prog_ack |=> !prog_ack)
		else $error("program ack longer than one cycle");
	chk_drive_start: assert property ($rose(tx_drive) |-> tx_valid)
		else $error("bus taken without a reply byte");
endmodule // mcf_interp_sva
bind mcf_interp mcf_interp_sva #(.REPLY_ADDR(REPLY_ADDR)) u_sva (.clk_sys, .reset, .can_mode,
	.tx_data, .tx_valid, .tx_ready, .tx_drive, .exec_start, .prog_ack);

// >>> dv/mcf_exec_model.sv
// Executor model: answers each execute strobe after a set delay.
// Assumes status and delay held by the bench during a command.
`timescale 1ns/100ps
module mcf_exec_model
	import mcf_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic exec_start,
	input wire mcf_pkg::mcf_cmd_s exec_cmd,
	input wire logic [7:0] st,
	input wire logic [3:0] dly,
	output logic exec_done,
	output mcf_pkg::mcf_res_s exec_res
);
	logic [4:0] cnt;
	always @(posedge clk_sys)
	begin
		exec_done <= 1'b0;
		exec_res <= ~exec_res; // Result is only valid with done
		if (reset)
			cnt <= 5'h00;
		else if (exec_start)
			cnt <= {1'b0, dly} + 5'h01;
		else if (cnt != 5'h00)
		begin
			cnt <= cnt - 5'h01;
			if (cnt == 5'h01)
			begin
				exec_done <= 1'b1;
				exec_res <= {st, exec_cmd.value + 32'h1};
			end
		end
	end
endmodule // mcf_exec_model

// >>> dv/mcf_interp_tb.sv
// Bench for the frame interpreter: random frames, each reply checked.
// Assumes executor model beside the design, random tx stalls.
`timescale 1ns/100ps
module mcf_interp_tb;
	import mcf_pkg::*;
	logic clk_sys = 0, reset = 1, can_mode = 0, rx_valid = 0, tx_ready = 0, prog_valid = 0;
	logic [7:0] rx_data = 8'h00, tx_data, st = 8'h64;
	logic [3:0] dly = 4'h0;
	logic tx_valid, tx_drive, prog_ack, exec_start, exec_done, cmd_error;
	mcf_cmd_s prog_cmd = '0, exec_cmd, ec;
	mcf_res_s exec_res;
	int errors = 0, n_compared = 0, nerr = 0, nex = 0, seed = 32'ha8c1a05c;
	logic [7:0] q[$];
	logic [7:0] sl[7] = '{8'h64, 8'h65, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
	mcf_interp dut (.clk_sys, .reset, .can_mode, .rx_data, .rx_valid, .tx_data, .tx_valid,
		.tx_ready, .tx_drive, .prog_valid, .prog_cmd, .prog_ack, .exec_cmd, .exec_start,
		.exec_done, .exec_res, .cmd_error);
	mcf_exec_model u_exec (.clk_sys, .reset, .exec_start, .exec_cmd, .st, .dly, .exec_done,
		.exec_res);
	initial forever #12.5 clk_sys = ~clk_sys;
	always @(negedge clk_sys) tx_ready <= 1'($random(seed)); // Host stalls at random
	always @(posedge clk_sys)
	begin
		if (tx_valid && tx_ready) q.push_back(tx_data);
		if (cmd_error) nerr++;
		if (exec_start)
		begin
			ec = exec_cmd;
			nex++;
		end
	end
	// Reply checksum from the expected reply fields, wrapped to 8 bits
	function automatic logic [7:0] rsum(input logic [7:0] st_v, input logic [7:0] c,
			input logic [31:0] v);
		rsum = 8'h02 + 8'h01 + st_v + c + v[31:24] + v[23:16] + v[15:8] + v[7:0];
	endfunction
	task chk(input logic [55:0] g, input logic [55:0] e);
		n_compared++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task put(input logic [7:0] b);
		@(negedge clk_sys);
		rx_data = b;
		rx_valid = 1;
		@(negedge clk_sys);
		rx_valid = 0;
	endtask
	task run(input logic cm, input logic [7:0] ad, input logic [7:0] sx, input logic [7:0] s);
		logic [7:0] f[9];
		logic [7:0] sm, es;
		logic [31:0] v;
		logic bad;
		int n, o;
		f[0] = ad;
		sm = ad;
		for (int i = 1; i < 8; i++)
		begin
			f[i] = 8'($random(seed));
			sm += f[i];
		end
		f[8] = sm + sx;
		// Checksum is only judged on serial frames
		bad = !cm && sx != 8'h00;
		es = bad ? 8'h01 : s;
		v = bad ? 32'h0000_0000 : {f[4], f[5], f[6], f[7]} + 32'h1;
		can_mode = cm;
		st = s;
		dly = 4'($random(seed));
		q.delete();
		nerr = 0;
		nex = 0;
		for (int i = cm; i < 9 - cm; i++) put(f[i]);
		repeat (80) @(negedge clk_sys);
		n = (!cm && ad != 8'h01) ? 0 : (cm ? 6 : 9);
		o = cm ? 0 : 2;
		chk(q.size(), n);
		chk(nerr, n != 0 && (bad || s < 8'h64));
		chk(nex, n != 0 && !bad);
		if (n == 0) return;
		chk(q[o], es);
		chk(q[o + 1], f[1]);
		if (!bad) chk(ec, {f[1], f[2], f[3], f[4], f[5], f[6], f[7]});
		chk({q[o + 2], q[o + 3], q[o + 4], q[o + 5]}, v);
		if (cm) return;
		chk({q[0], q[1]}, 16'h0201);
		chk(q[8], rsum(es, f[1], v));
	endtask
	task final_report;
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#200000;
		errors++;
		final_report;
	end
	initial
	begin
		repeat (3) @(negedge clk_sys);
		reset = 0;
		foreach (sl[i]) run(0, 8'h01, 8'h00, sl[i]);
		run(1, 8'h01, 8'h00, 8'h64);
		run(1, 8'h01, 8'h00, 8'h03);
		run(0, 8'h01, 8'h5A, 8'h64);
		run(0, 8'h05, 8'h00, 8'h64);
		q.delete();
		nex = 0;
		prog_cmd = 56'({$random(seed), $random(seed)});
		prog_valid = 1;
		// Ack looked at on the falling edge, where it stands settled
		for (int i = 0; i < 20 && !prog_ack; i++) @(negedge clk_sys);
		chk(prog_ack, 1'b1);
		prog_valid = 0;
		repeat (40) @(negedge clk_sys);
		chk(ec, prog_cmd);
		chk(nex, 1);
		chk(q.size(), 0);
		final_report;
	end
endmodule // mcf_interp_tb
